//--- ddbm_bus_master.sv
// Purpose: System bus master control for diskette memory transfers
// Assumes: Bus clock and microprogram pins synchronous to clk_sys
// Notes: Bus steps ride the bus clock falls seen by an edge detector, except the command end, which follows the acknowledge
// Functional notes
// - Own the shared bus before any memory data transfer.
// - Request pulse sets transfer latch unless write-inhibit latch set.
// - Write-inhibit latch set during verify-only operations.
// - Inhibit latch set and cleared by dedicated microprogram pulses.
// - Transfer latch sampled on next bus clock falling edge.
// - Drive active-low transfer pending while transfer incomplete.
// - New request while pending sets overrun latch and error line; the code ignores it instead while the write-inhibit latch is set.
// - Latched request starts bus cycle by driving bus request low.
// - First bus clock edge with bus free and priority in: assert busy.
// - Keep busy asserted while holding mastership.
// - On winning, enable address drivers and report bus owned.
// - Next edge after busy: write command if write select, else read.
`timescale 1ns/1ps
`default_nettype none

module ddbm_bus_master
  import ddbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ddbm_axi_req_s axiReq,
  output wire ddbm_axi_rsp_s axiRsp,
  output logic irq,
  input wire logic busClockN,
  input wire logic busyNIn,
  input wire logic busPrioInN,
  input wire logic xferAckN,
  output wire ddbm_sysbus_s sysBus,
  input wire logic memoryRequestPulseN,
  input wire logic setWriteInhibitPulseN,
  input wire logic clearWriteInhibitPulseN,
  input wire logic memWriteSelect,
  output wire ddbm_chan_s chan
);

  function automatic logic regHit(input logic [`DDBM_ADDR_W-1:0] addr);
    regHit = (addr == `DDBM_OFF_CTRL) || (addr == `DDBM_OFF_MASK) ||
             (addr == `DDBM_OFF_STATUS) || (addr == `DDBM_OFF_STATE);
  endfunction : regHit

  logic [3:0] fall;
  logic bclkFall, reqPulse, setInh, clrInh;

  ddbm_fall_detect #(
    .W(4)
  ) u_fall (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .sigIn({clearWriteInhibitPulseN, setWriteInhibitPulseN, memoryRequestPulseN, busClockN}),
    .fall(fall)
  );

  assign bclkFall = fall[0];
  assign reqPulse = fall[1];
  assign setInh = fall[2];
  assign clrInh = fall[3];

  // Register file state
  logic ctrlEnable;
  logic [`DDBM_EV_W-1:0] irqMask;
  logic [`DDBM_EV_W-1:0] irqStatus;

  // AXI4-Lite slave state
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [`DDBM_ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic wrGo, wrOk, rdGo, statusReadClear, clrOverrun;
  logic [31:0] next_rData;

  // Transfer latches and bus outputs
  logic writeInhibit, transferPendingN, overrunErrorN, busOwned;
  logic busReqN, busyDrive, busyNOut;
  logic memReadCmdN, memWriteCmdN, addressDriveEnableN;
  ddbm_state_e state;
  logic [`DDBM_EV_W-1:0] events;
  logic [`DDBM_EV_W-1:0] next_status;

  // Write path: address and data taken in either order, answer after both
  assign wrGo = !awReady && !wReady && !bValid;
  assign wrOk = regHit(awAddrQ);
  assign clrOverrun = wrGo && wrOk && wStrbQ[0] && (awAddrQ == `DDBM_OFF_CTRL) &&
                      wDataQ[`DDBM_CTRL_CLR_OVERRUN];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awReady <= 1'b1;
      awAddrQ <= '0;
    end else if (awReady && axiReq.awvalid) begin
      awReady <= 1'b0;
      awAddrQ <= axiReq.awaddr;
    end else if (bValid && axiReq.bready) begin
      awReady <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wReady <= 1'b1;
      wDataQ <= '0;
      wStrbQ <= '0;
    end else if (wReady && axiReq.wvalid) begin
      wReady <= 1'b0;
      wDataQ <= axiReq.wdata;
      wStrbQ <= axiReq.wstrb;
    end else if (bValid && axiReq.bready) begin
      wReady <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bValid <= 1'b0;
      bResp <= `DDBM_RESP_OKAY;
    end else if (wrGo) begin
      bValid <= 1'b1;
      bResp <= wrOk ? `DDBM_RESP_OKAY : `DDBM_RESP_SLVERR;
    end else if (bValid && axiReq.bready) begin
      bValid <= 1'b0;
    end
  end

  // Only the low byte lane carries register bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrlEnable <= 1'(`DDBM_CTRL_RESET);
      irqMask <= `DDBM_EV_W'(`DDBM_MASK_RESET);
    end else if (wrGo && wStrbQ[0]) begin
      if (awAddrQ == `DDBM_OFF_CTRL) begin
        ctrlEnable <= wDataQ[`DDBM_CTRL_ENABLE];
      end
      if (awAddrQ == `DDBM_OFF_MASK) begin
        irqMask <= wDataQ[`DDBM_EV_W-1:0];
      end
    end
  end

  // Read path: data one cycle after the address is taken
  assign rdGo = arReady && axiReq.arvalid;
  assign statusReadClear = rdGo && (axiReq.araddr == `DDBM_OFF_STATUS);

  always_comb begin
    next_rData = '0;
    case (axiReq.araddr)
      `DDBM_OFF_CTRL: begin
        next_rData[`DDBM_CTRL_ENABLE] = ctrlEnable;
      end
      `DDBM_OFF_MASK: begin
        next_rData[`DDBM_EV_W-1:0] = irqMask;
      end
      `DDBM_OFF_STATUS: begin
        next_rData[`DDBM_EV_W-1:0] = irqStatus;
      end
      `DDBM_OFF_STATE: begin
        next_rData[`DDBM_ST_PENDING] = !transferPendingN;
        next_rData[`DDBM_ST_OVERRUN] = !overrunErrorN;
        next_rData[`DDBM_ST_INHIBIT] = writeInhibit;
        next_rData[`DDBM_ST_OWNED] = busOwned;
        next_rData[`DDBM_ST_FSM_LO +: 3] = state;
      end
      default: begin
        next_rData = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      arReady <= 1'b1;
      rValid <= 1'b0;
      rData <= '0;
      rResp <= `DDBM_RESP_OKAY;
    end else if (rdGo) begin
      arReady <= 1'b0;
      rValid <= 1'b1;
      rData <= next_rData;
      rResp <= regHit(axiReq.araddr) ? `DDBM_RESP_OKAY : `DDBM_RESP_SLVERR;
    end else if (rValid && axiReq.rready) begin
      rValid <= 1'b0;
      arReady <= 1'b1;
    end
  end

  // Write-inhibit latch; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      writeInhibit <= 1'b0;
    end else if (setInh) begin
      writeInhibit <= 1'b1;
    end else if (clrInh) begin
      writeInhibit <= 1'b0;
    end
  end

  // Transfer request latch, kept in its active-low pin form
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      transferPendingN <= 1'b1;
    end else if (reqPulse && !writeInhibit) begin
      transferPendingN <= 1'b0;
    end else if (state == DDBM_REL && bclkFall) begin
      transferPendingN <= 1'b1;
    end
  end

  // Overrun holds until software clears it; a new overrun beats the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overrunErrorN <= 1'b1;
    end else if (reqPulse && !writeInhibit && !transferPendingN) begin
      overrunErrorN <= 1'b0;
    end else if (clrOverrun) begin
      overrunErrorN <= 1'b1;
    end
  end

  // Bus sequencer, stepping on bus clock falling edges except the command end, which steps on the acknowledge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= DDBM_IDLE;
      busReqN <= 1'b1;
      busyDrive <= 1'b0;
      busyNOut <= 1'b1;
      addressDriveEnableN <= 1'b1;
      busOwned <= 1'b0;
      memReadCmdN <= 1'b1;
      memWriteCmdN <= 1'b1;
    end else begin
      case (state)
        DDBM_IDLE: begin
          // Disabled channel leaves the request pending, not lost
          if (bclkFall && !transferPendingN && ctrlEnable) begin
            state <= DDBM_ARB;
            busReqN <= 1'b0;
          end
        end
        DDBM_ARB: begin
          if (bclkFall && busyNIn && !busPrioInN) begin
            state <= DDBM_OWN;
            busyDrive <= 1'b1;
            busyNOut <= 1'b0;
            addressDriveEnableN <= 1'b0;
            busOwned <= 1'b1;
          end
        end
        DDBM_OWN: begin
          if (bclkFall) begin
            state <= DDBM_CMD;
            memWriteCmdN <= !memWriteSelect;
            memReadCmdN <= memWriteSelect;
          end
        end
        DDBM_CMD: begin
          if (!xferAckN) begin
            state <= DDBM_REL;
            memReadCmdN <= 1'b1;
            memWriteCmdN <= 1'b1;
          end
        end
        DDBM_REL: begin
          // Busy held to the next bus clock edge so the command release settles first
          if (bclkFall) begin
            state <= DDBM_IDLE;
            busReqN <= 1'b1;
            busyDrive <= 1'b0;
            busyNOut <= 1'b1;
            addressDriveEnableN <= 1'b1;
            busOwned <= 1'b0;
          end
        end
        default: begin
          state <= DDBM_IDLE;
        end
      endcase
    end
  end

  // Sticky status cleared by a read; events in the read cycle survive
  always_comb begin
    events = '0;
    events[`DDBM_EV_DONE] = (state == DDBM_REL) && bclkFall;
    events[`DDBM_EV_OVERRUN] = reqPulse && !writeInhibit && !transferPendingN;
    events[`DDBM_EV_IGNORED] = reqPulse && writeInhibit;
    next_status = (statusReadClear ? '0 : irqStatus) | events;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqStatus <= '0;
    end else begin
      irqStatus <= next_status;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & irqMask);
    end
  end

  assign axiRsp.awready = awReady;
  assign axiRsp.wready = wReady;
  assign axiRsp.bvalid = bValid;
  assign axiRsp.bresp = bResp;
  assign axiRsp.arready = arReady;
  assign axiRsp.rvalid = rValid;
  assign axiRsp.rdata = rData;
  assign axiRsp.rresp = rResp;

  assign sysBus.busReqN = busReqN;
  assign sysBus.busyNOut = busyNOut;
  assign sysBus.busyOe = busyDrive;
  assign sysBus.memReadCmdN = memReadCmdN;
  assign sysBus.memWriteCmdN = memWriteCmdN;
  assign sysBus.addressDriveEnableN = addressDriveEnableN;

  assign chan.transferPendingN = transferPendingN;
  assign chan.overrunErrorN = overrunErrorN;
  assign chan.busOwned = busOwned;

endmodule : ddbm_bus_master

`default_nettype wire

//--- ddbm_regs.svh
// Purpose: Register offsets, field positions and reset values for the disk bus master
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address
// Notes: Definitions only
`ifndef DDBM_REGS_SVH
`define DDBM_REGS_SVH

`define DDBM_ADDR_W 8
`define DDBM_OFF_CTRL 8'h00
`define DDBM_OFF_MASK 8'h04
`define DDBM_OFF_STATUS 8'h08
`define DDBM_OFF_STATE 8'h0C

`define DDBM_CTRL_ENABLE 0
`define DDBM_CTRL_CLR_OVERRUN 1

`define DDBM_EV_DONE 0
`define DDBM_EV_OVERRUN 1
`define DDBM_EV_IGNORED 2
`define DDBM_EV_W 3

`define DDBM_ST_PENDING 0
`define DDBM_ST_OVERRUN 1
`define DDBM_ST_INHIBIT 2
`define DDBM_ST_OWNED 3
`define DDBM_ST_FSM_LO 4

`define DDBM_CTRL_RESET 32'h0000_0001
`define DDBM_MASK_RESET 32'h0000_0000
`define DDBM_RESP_OKAY 2'h0
`define DDBM_RESP_SLVERR 2'h2

`endif

//--- ddbm_pkg.sv
// Purpose: Types shared by the disk bus master files
// Assumes: ddbm_regs.svh gives the address width
// Notes: AXI signals keep their published names
`include "ddbm_regs.svh"

package ddbm_pkg;

  typedef enum logic [2:0] {
    DDBM_IDLE,
    DDBM_ARB,
    DDBM_OWN,
    DDBM_CMD,
    DDBM_REL
  } ddbm_state_e;

  typedef struct packed {
    logic awvalid;
    logic [`DDBM_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`DDBM_ADDR_W-1:0] araddr;
    logic rready;
  } ddbm_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ddbm_axi_rsp_s;

  typedef struct packed {
    logic busReqN;
    logic busyNOut;
    logic busyOe;
    logic memReadCmdN;
    logic memWriteCmdN;
    logic addressDriveEnableN;
  } ddbm_sysbus_s;

  typedef struct packed {
    logic transferPendingN;
    logic overrunErrorN;
    logic busOwned;
  } ddbm_chan_s;

endpackage : ddbm_pkg

//--- ddbm_fall_detect.sv
// Purpose: Falling-edge pulses for a group of active-low inputs
// Assumes: Inputs synchronous to clk_sys
// Notes: Idle level is high, so reset preloads ones
`timescale 1ns/1ps
`default_nettype none

module ddbm_fall_detect #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] sigIn,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev <= '1;
      fall <= '0;
    end else begin
      prev <= sigIn;
      fall <= prev & ~sigIn;
    end
  end

endmodule : ddbm_fall_detect

`default_nettype wire

//--- ddbm_monitor.sv
// Purpose: Assertions on the disk bus master pins
// Assumes: Busy and priority inputs stay steady around bus clock falls
// Notes: Bound to every ddbm_bus_master
`timescale 1ns/1ps
`default_nettype none
module ddbm_monitor
  import ddbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic busyNIn,
  input wire logic busPrioInN,
  input wire logic xferAckN,
  input wire logic memWriteSelect,
  input wire ddbm_sysbus_s sysBus,
  input wire ddbm_chan_s chan
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_cmdOn;
    !sysBus.memReadCmdN || !sysBus.memWriteCmdN;
  endsequence
  sequence s_owned;
    !sysBus.busyNOut && sysBus.busyOe && chan.busOwned && !sysBus.addressDriveEnableN;
  endsequence
  property p_reqPend;
    !sysBus.busReqN |-> !chan.transferPendingN;
  endproperty
  a_reqPend: assert property (p_reqPend) else $error("bus request while idle");
  property p_cmdOwn;
    s_cmdOn |-> s_owned;
  endproperty
  a_cmdOwn: assert property (p_cmdOwn) else $error("command without bus");
  property p_win;
    $fell(sysBus.busyNOut) |-> $past(busyNIn) && !$past(busPrioInN) && !sysBus.busReqN;
  endproperty
  a_win: assert property (p_win) else $error("busy taken without grant");
  property p_own;
    $fell(sysBus.busyNOut) |-> s_owned;
  endproperty
  a_own: assert property (p_own) else $error("address enable missing");
  property p_hold;
    sysBus.busyOe |-> !sysBus.busyNOut && !sysBus.busReqN;
  endproperty
  a_hold: assert property (p_hold) else $error("busy not held");
  property p_selWr;
    $fell(sysBus.memWriteCmdN) |-> $past(memWriteSelect) && !$past(sysBus.busyNOut);
  endproperty
  a_selWr: assert property (p_selWr) else $error("wrong write command");
  property p_selRd;
    $fell(sysBus.memReadCmdN) |-> !$past(memWriteSelect) && !$past(sysBus.busyNOut);
  endproperty
  a_selRd: assert property (p_selRd) else $error("wrong read command");
  property p_ack;
    s_cmdOn ##0 !xferAckN |=> sysBus.memReadCmdN && sysBus.memWriteCmdN ##[1:12] chan.transferPendingN;
  endproperty
  a_ack: assert property (p_ack) else $error("command not ended");
  property p_rel;
    $rose(sysBus.busyNOut) |-> sysBus.busReqN && chan.transferPendingN && !chan.busOwned;
  endproperty
  a_rel: assert property (p_rel) else $error("partial release");
  property p_ovr;
    $fell(chan.overrunErrorN) |-> !$past(chan.transferPendingN);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun while idle");
endmodule : ddbm_monitor
bind ddbm_bus_master ddbm_monitor mon (.clk_sys(clk_sys), .resetn(resetn), .busyNIn(busyNIn),
  .busPrioInN(busPrioInN), .xferAckN(xferAckN), .memWriteSelect(memWriteSelect),
  .sysBus(sysBus), .chan(chan));
`default_nettype wire

//--- ddbm_sys_model.sv
// Purpose: Shared bus with memory and one rival master
// Assumes: Bus clock of 8 clk_sys cycles
// Notes: Rival and priority change only just after a bus clock rise
`timescale 1ns/1ps
`default_nettype none
module ddbm_sys_model
  import ddbm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire ddbm_sysbus_s sysBus,
  input wire logic otherBusy,
  input wire logic noPrio,
  input wire logic [3:0] ackDelay,
  output logic busClockN,
  output logic busyNIn,
  output logic busPrioInN,
  output logic xferAckN
);
  logic [2:0] div;
  logic [3:0] ackCnt;
  logic rivalN;
  // Busy line is pulled up, so any driver can pull it low
  assign busyNIn = rivalN & (sysBus.busyOe ? sysBus.busyNOut : 1'b1);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div <= '0;
      busClockN <= 1'b1;
      rivalN <= 1'b1;
      busPrioInN <= 1'b0;
    end else begin
      div <= div + 3'h1;
      busClockN <= ~div[2];
      if (div == 3'h0) begin
        rivalN <= !otherBusy;
        busPrioInN <= noPrio;
      end
    end
  end
  // Slow memory holds ack until the command is gone
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ackCnt <= '0;
      xferAckN <= 1'b1;
    end else if (!sysBus.memReadCmdN || !sysBus.memWriteCmdN) begin
      ackCnt <= ackCnt + 4'h1;
      xferAckN <= ackCnt < ackDelay;
    end else begin
      ackCnt <= '0;
      xferAckN <= 1'b1;
    end
  end
endmodule : ddbm_sys_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the disk bus master
// Assumes: Partner model drives the shared bus side
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb
  import ddbm_pkg::*;
;
  logic clk_sys = '0;
  logic resetn = '0;
  ddbm_axi_req_s req = '0;
  ddbm_axi_rsp_s rsp;
  ddbm_sysbus_s sysBus;
  ddbm_chan_s chan;
  logic [2:0] pulN = 3'h7;
  logic wrSel = '0, otherBusy = '0, noPrio = '0;
  logic [3:0] ackDelay = 4'h1;
  logic irq, busClockN, busyNIn, busPrioInN, xferAckN;
  int numErrors = 0, compares = 0;
  ddbm_bus_master dut (.clk_sys(clk_sys), .resetn(resetn), .axiReq(req), .axiRsp(rsp), .irq(irq),
    .busClockN(busClockN), .busyNIn(busyNIn), .busPrioInN(busPrioInN), .xferAckN(xferAckN),
    .sysBus(sysBus), .memoryRequestPulseN(pulN[0]), .setWriteInhibitPulseN(pulN[1]),
    .clearWriteInhibitPulseN(pulN[2]), .memWriteSelect(wrSel), .chan(chan));
  ddbm_sys_model far (.clk_sys(clk_sys), .resetn(resetn), .sysBus(sysBus), .otherBusy(otherBusy),
    .noPrio(noPrio), .ackDelay(ackDelay), .busClockN(busClockN), .busyNIn(busyNIn),
    .busPrioInN(busPrioInN), .xferAckN(xferAckN));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic completeRun;
    $display("errors=%0d compares=%0d", numErrors, compares);
    if (numErrors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : completeRun
  task automatic guard(input int n);
    if (n >= 600) begin
      numErrors++;
      completeRun();
    end
  endtask : guard
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 600);
    req.bready <= 1'b0;
    guard(n);
    check(rsp.bresp, 32'h0);
  endtask : axiWr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 600);
    req.rready <= 1'b0;
    guard(n);
    check(rsp.rdata, exp);
    check(rsp.rresp, er);
  endtask : rdChk
  task automatic pulse(input int k);
    @(posedge clk_sys);
    pulN[k] <= 1'b0;
    @(posedge clk_sys);
    pulN[k] <= 1'b1;
  endtask : pulse
  task automatic go(input logic wr, input logic [3:0] dly);
    wrSel <= wr;
    ackDelay <= dly;
    pulse(0);
    repeat (3) @(posedge clk_sys);
    check(chan.transferPendingN, 32'h0);
  endtask : go
  task automatic done(input logic wr, input logic ovrN);
    int n;
    logic [1:0] cmd;
    cmd = '0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      cmd = cmd | ~{sysBus.memWriteCmdN, sysBus.memReadCmdN};
    end while (chan.transferPendingN !== 1'b1 && n < 600);
    guard(n);
    check(cmd, {wr, ~wr});
    check({sysBus, chan}, {6'h37, 1'b1, ovrN, 1'b0});
  endtask : done
  task automatic t_reset;
    check({sysBus, chan, irq}, 10'h37c);
    rdChk(8'h00, 32'h1, 2'h0);
    rdChk(8'h04, 32'h0, 2'h0);
  endtask : t_reset
  // Disabled channel must hold the latched request without asking for the bus
  task automatic t_read;
    axiWr(8'h00, 32'h0);
    go(1'b0, 4'h0);
    repeat (30) @(posedge clk_sys);
    check({sysBus.busReqN, chan.transferPendingN}, 32'h2);
    axiWr(8'h00, 32'h1);
    done(1'b0, 1'b1);
    rdChk(8'h08, 32'h1, 2'h0);
    rdChk(8'h08, 32'h0, 2'h0);
    check(irq, 32'h0);
  endtask : t_read
  // Rival holds the bus, then priority is withheld on its own
  task automatic t_contend;
    otherBusy <= 1'b1;
    noPrio <= 1'b1;
    go(1'b1, 4'h9);
    repeat (40) @(posedge clk_sys);
    check({sysBus.busReqN, chan.busOwned}, 32'h0);
    otherBusy <= 1'b0;
    repeat (24) @(posedge clk_sys);
    check(chan.busOwned, 32'h0);
    noPrio <= 1'b0;
    done(1'b1, 1'b1);
  endtask : t_contend
  task automatic t_overrun;
    axiWr(8'h04, 32'h2);
    go(1'b0, 4'h3);
    pulse(0);
    repeat (4) @(posedge clk_sys);
    check(chan.overrunErrorN, 32'h0);
    check(irq, 32'h1);
    done(1'b0, 1'b0);
    rdChk(8'h08, 32'h3, 2'h0);
    repeat (2) @(posedge clk_sys);
    check(irq, 32'h0);
    axiWr(8'h00, 32'h3);
    repeat (2) @(posedge clk_sys);
    check(chan.overrunErrorN, 32'h1);
  endtask : t_overrun
  task automatic t_inhibit;
    pulse(1);
    pulse(0);
    repeat (6) @(posedge clk_sys);
    check(chan.transferPendingN, 32'h1);
    rdChk(8'h0c, 32'h4, 2'h0);
    rdChk(8'h08, 32'h4, 2'h0);
    pulse(2);
    go(1'b1, 4'h0);
    done(1'b1, 1'b1);
    rdChk(8'h10, 32'h0, 2'h2);
  endtask : t_inhibit
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_read();
    t_contend();
    t_overrun();
    t_inhibit();
    completeRun();
  end
endmodule : tb
`default_nettype wire
